// File: rtl/ecmb_defines.vh
`ifndef ECMB_DEFINES_VH
`define ECMB_DEFINES_VH
`define ECMB_PAGE_ADDR 28'h01E0000
`define ECMB_PAGE_HI 27
`define ECMB_PAGE_LO 13
`define ECMB_PAGE_NUM 15'h00F0
`define ECMB_OFF_ENABLE 4'h0
`define ECMB_OFF_CE 4'h4
`define ECMB_OFF_DIAG 4'h8
`define ECMB_BASE_HI 5
`define ECMB_BIT_BOARD_EN 6
`define ECMB_BIT_BUS_ECC 7
`define ECMB_BIT_SCRUB 8
`define ECMB_SIZE_HI 10
`define ECMB_SIZE_LO 9
`define ECMB_BIT_MODE0 11
`define ECMB_BIT_MODE1 12
`define ECMB_TYPE_HI 15
`define ECMB_TYPE_LO 13
`define ECMB_ENABLE_RESET 5'h00
`define ECMB_BASE_RESET 6'h00
`define ECMB_CE_RESET 32'h00000000
`endif

// File: rtl/ecmb_base_match.v
`timescale 1ns/1ps
module ecmb_base_match (
    input wire [5:0] i_base,
    input wire [1:0] i_size,
    input wire [5:0] i_addr_hi,
    output wire o_hit
);
    wire [5:0] mask;
    assign mask = (i_size == 2'h0) ? 6'h3F : (i_size == 2'h1) ? 6'h3E :
                  (i_size == 2'h2) ? 6'h3C : 6'h38;
    assign o_hit = ((i_addr_hi & mask) == (i_base & mask));
endmodule

// File: rtl/ecmb_regs.v
`timescale 1ns/1ps
`include "ecmb_defines.vh"
// Overview of operation
// - Registers answer only in page 0x001E0000
// - A7:A6 must match jumper board number
// - A3:A0 picks enable, error, diagnostic register
// - Base field compared with A27..A22
// - Select when enabled and in range
// - Size field reports board capacity
// - Enable clears on reset, blocks memory
// - Bit 7 enables bus check and reporting
// - Bit 8 enables scrub with error report
// - Bits 11,12 drive chip mode selects
// - Bits 15..13 read fixed board version
// - Error register captures first syndrome, address
// - Top byte write clears error register
// - Status bit set freezes captured fields
// - Captured address is A25..A3
// - Bits 31..24 hold captured syndrome
// - Diagnostic is four write-only chip words
// - Board error flag feeds processor flag
// - Scrub uncorrectable errors go unreported
module ecmb_regs #(
    parameter [1:0] BOARD_SIZE = 2'h0,
    parameter [2:0] BOARD_VERSION = 3'h0
) (
    input wire I_CORE_CLK,
    input wire I_RESET_N,
    input wire [1:0] I_BOARD_NUM,
    input wire I_REG_SEL,
    input wire I_REG_WR,
    input wire I_REG_RD,
    input wire [27:0] I_REG_ADDR,
    input wire [1:0] I_REG_SIZE,
    input wire [31:0] I_REG_WDATA,
    input wire I_MEM_CYCLE,
    input wire [27:0] I_MEM_ADDR,
    input wire I_CE_DET,
    input wire I_UE_DET,
    input wire I_SCRUB_CYCLE,
    input wire [7:0] I_CE_SYNDROME,
    output reg O_REG_ACK,
    output reg [31:0] O_REG_RDATA,
    output reg O_BOARD_SEL,
    output reg O_CHECK_GEN_EN,
    output reg O_SCRUB_EN,
    output reg O_CHIP_MODE_SEL0,
    output reg O_CHIP_MODE_SEL1,
    output reg O_CE_REPORT,
    output reg O_UE_REPORT,
    output reg O_CE_STATUS,
    output reg [3:0] O_DIAG_WR,
    output reg [15:0] O_DIAG_DATA
);
    reg rst_s1_reg;
    reg rst_n_reg;
    reg [1:0] bnum_s1_reg;
    reg [1:0] bnum_reg;
    reg [4:0] enable_reg;
    reg [4:0] enable_next;
    reg [5:0] base_reg;
    reg [5:0] base_next;
    reg [31:0] ce_reg;
    reg [31:0] ce_next;
    reg [31:0] rdata_next;
    reg [15:0] diag_data_next;
    wire rst_n;
    wire page_hit;
    wire board_hit;
    wire reg_hit;
    wire [3:0] reg_off;
    wire ack_next;
    wire range_hit;
    wire mem_sel;
    wire [15:0] enable_view;
    wire wr_en;
    wire wr_ce;
    wire diag_aligned;
    wire wr_diag;
    wire ce_event;
    wire ue_event;
    wire [3:0] diag_wr_next;
    genvar chip;

    assign rst_n = rst_n_reg;

    // Reset release synchroniser
    always @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg <= rst_s1_reg;
        end
    end

    // Jumper board number synchroniser
    always @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            bnum_s1_reg <= 2'h0;
            bnum_reg <= 2'h0;
        end else begin
            bnum_s1_reg <= I_BOARD_NUM;
            bnum_reg <= bnum_s1_reg;
        end
    end

    assign page_hit = (I_REG_ADDR[`ECMB_PAGE_HI:`ECMB_PAGE_LO] == `ECMB_PAGE_NUM);

    assign board_hit = (I_REG_ADDR[7:6] == bnum_reg);
    assign reg_hit = I_REG_SEL && page_hit && board_hit;

    assign reg_off = I_REG_ADDR[3:0];
    assign ack_next = reg_hit && (I_REG_WR || I_REG_RD);
    assign wr_en = reg_hit && I_REG_WR && (reg_off == `ECMB_OFF_ENABLE);

    assign wr_ce = reg_hit && I_REG_WR && (reg_off == `ECMB_OFF_CE);

    assign diag_aligned = (I_REG_SIZE == 2'h1) ? !I_REG_ADDR[0] :
                          (I_REG_ADDR[1:0] == 2'h0);
    assign wr_diag = reg_hit && I_REG_WR && reg_off[3] &&
                     (I_REG_SIZE != 2'h0) && diag_aligned;

    assign enable_view = {BOARD_VERSION, enable_reg[4], enable_reg[3], BOARD_SIZE,
                          enable_reg[2], enable_reg[1], enable_reg[0], base_reg};

    always @* begin
        enable_next = enable_reg;
        base_next = base_reg;
        if (wr_en) begin
            enable_next = {I_REG_WDATA[`ECMB_BIT_MODE1], I_REG_WDATA[`ECMB_BIT_MODE0],
                           I_REG_WDATA[`ECMB_BIT_SCRUB], I_REG_WDATA[`ECMB_BIT_BUS_ECC],
                           I_REG_WDATA[`ECMB_BIT_BOARD_EN]};
            base_next = I_REG_WDATA[`ECMB_BASE_HI:0];
        end
    end

    ecmb_base_match u_match (
        .i_base(base_reg),
        .i_size(BOARD_SIZE),
        .i_addr_hi(I_MEM_ADDR[27:22]),
        .o_hit(range_hit)
    );

    assign mem_sel = I_MEM_CYCLE && enable_reg[0] && range_hit;

    assign ce_event = I_CE_DET && (I_SCRUB_CYCLE ? O_SCRUB_EN : O_CHECK_GEN_EN);

    assign ue_event = I_UE_DET && !I_SCRUB_CYCLE && O_CHECK_GEN_EN;

    always @* begin
        ce_next = ce_reg;
        if (wr_ce) begin
            ce_next = `ECMB_CE_RESET;
        end
        if (ce_event && (!ce_reg[0] || wr_ce)) begin
            ce_next = {I_CE_SYNDROME, I_MEM_ADDR[25:3], 1'b1};
        end
    end

    // Read data select
    always @* begin
        rdata_next = 32'h00000000;
        case (reg_off)
            `ECMB_OFF_ENABLE: begin
                rdata_next = {16'h0000, enable_view};
            end
            `ECMB_OFF_CE: begin
                rdata_next = ce_reg;
            end
            default: begin
                rdata_next = 32'h00000000;
            end
        endcase
    end

    generate
        for (chip = 0; chip < 4; chip = chip + 1) begin : g_chip
            wire word_hit;
            wire pair_hit;
            assign word_hit = ({30'h00000000, I_REG_ADDR[2:1]} == chip);
            assign pair_hit = ({31'h00000000, I_REG_ADDR[2]} == (chip / 2));
            assign diag_wr_next[chip] = wr_diag &&
                                        ((I_REG_SIZE == 2'h1) ? word_hit : pair_hit);
        end
    endgenerate

    // Diagnostic data, low half only
    always @* begin
        diag_data_next = 16'h0000;
        if (wr_diag) begin
            diag_data_next = I_REG_WDATA[15:0];
        end
    end

    // Control and capture registers
    always @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            enable_reg <= `ECMB_ENABLE_RESET;
            base_reg <= `ECMB_BASE_RESET;
            ce_reg <= `ECMB_CE_RESET;
        end else begin
            enable_reg <= enable_next;
            base_reg <= base_next;
            ce_reg <= ce_next;
        end
    end

    // Register access acknowledge
    always @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_REG_ACK <= 1'b0;
        end else begin
            O_REG_ACK <= ack_next;
        end
    end

    // Read data, zero outside reads
    always @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_REG_RDATA <= 32'h00000000;
        end else begin
            O_REG_RDATA <= (reg_hit && I_REG_RD) ? rdata_next : 32'h00000000;
        end
    end

    // Memory side controls
    always @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_BOARD_SEL <= 1'b0;
            O_CHECK_GEN_EN <= 1'b0;
            O_SCRUB_EN <= 1'b0;
            O_CHIP_MODE_SEL0 <= 1'b0;
            O_CHIP_MODE_SEL1 <= 1'b0;
        end else begin
            O_BOARD_SEL <= mem_sel;
            O_CHECK_GEN_EN <= enable_reg[1];
            O_SCRUB_EN <= enable_reg[2];
            O_CHIP_MODE_SEL0 <= enable_reg[3];
            O_CHIP_MODE_SEL1 <= enable_reg[4];
        end
    end

    // Error reports
    always @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_CE_REPORT <= 1'b0;
            O_UE_REPORT <= 1'b0;
            O_CE_STATUS <= 1'b0;
        end else begin
            O_CE_REPORT <= ce_event;
            O_UE_REPORT <= ue_event;
            O_CE_STATUS <= ce_next[0];
        end
    end

    // Chip diagnostic strobes
    always @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_DIAG_WR <= 4'h0;
            O_DIAG_DATA <= 16'h0000;
        end else begin
            O_DIAG_WR <= diag_wr_next;
            O_DIAG_DATA <= diag_data_next;
        end
    end
endmodule

// File: testbench/ecmb_chk_checker.sv
`timescale 1ns/1ps
module ecmb_chk (
    input wire I_CORE_CLK, I_RESET_N, I_REG_SEL, I_REG_WR, I_REG_RD, I_CE_DET,
    input wire I_UE_DET, I_SCRUB_CYCLE, O_REG_ACK, O_CHECK_GEN_EN, O_CHIP_MODE_SEL0,
    input wire O_CE_STATUS, O_UE_REPORT,
    input wire [1:0] I_BOARD_NUM, I_REG_SIZE,
    input wire [27:0] I_REG_ADDR,
    input wire [31:0] I_REG_WDATA, O_REG_RDATA,
    input wire [3:0] O_DIAG_WR
);
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RESET_N);
    sequence s_ce;
        I_CE_DET && !I_SCRUB_CYCLE && O_CHECK_GEN_EN && !(I_REG_SEL && I_REG_WR);
    endsequence
    sequence s_clr;
        O_REG_ACK && $past(I_REG_WR && I_REG_ADDR[3:0] == 4'h4 && !I_CE_DET);
    endsequence
    property p_ack;
        O_REG_ACK |-> $past(I_REG_SEL && I_REG_ADDR[27:13] == 15'h00F0
            && I_REG_ADDR[7:6] == I_BOARD_NUM);
    endproperty
    a_ack: assert property (p_ack) else $error("ack outside page or board");
    property p_ce; s_ce |=> O_CE_STATUS; endproperty
    a_ce: assert property (p_ce) else $error("error not captured");
    property p_clr; s_clr |-> !O_CE_STATUS; endproperty
    a_clr: assert property (p_clr) else $error("error status not cleared");
    property p_fall;
        $fell(O_CE_STATUS) |-> $past(I_REG_SEL && I_REG_WR && I_REG_ADDR[3:0] == 4'h4);
    endproperty
    a_fall: assert property (p_fall) else $error("error status dropped");
    property p_ue; O_UE_REPORT |-> $past(I_UE_DET && !I_SCRUB_CYCLE && O_CHECK_GEN_EN); endproperty
    a_ue: assert property (p_ue) else $error("bad uncorrectable report");
    property p_mode0;
        $changed(O_CHIP_MODE_SEL0) |-> $past(O_REG_ACK) &&
            O_CHIP_MODE_SEL0 == $past(I_REG_WDATA[11], 2);
    endproperty
    a_mode0: assert property (p_mode0) else $error("mode select wrong");
    property p_drd; O_REG_ACK && $past(I_REG_RD && I_REG_ADDR[3]) |-> O_REG_RDATA == 32'h0; endproperty
    a_drd: assert property (p_drd) else $error("diagnostic readable");
    property p_dwr;
        O_DIAG_WR != 4'h0 |-> $past(I_REG_SEL && I_REG_WR && I_REG_SIZE != 2'h0 && I_REG_ADDR[3]);
    endproperty
    a_dwr: assert property (p_dwr) else $error("bad diagnostic write");
endmodule
bind ecmb_regs ecmb_chk u_chk (.*);

// File: testbench/ecmb_mem_master.sv
`timescale 1ns/1ps
module ecmb_mem_master (
    input wire i_clk,
    output reg [3:0] o_flags,
    output reg [27:0] o_mem_addr,
    output reg [7:0] o_ce_syndrome
);
    initial {o_flags, o_mem_addr, o_ce_syndrome} = 40'h0;
    task cyc(input [27:0] a, input [3:0] f, input [7:0] s);
        begin
            @(negedge i_clk);
            {o_flags, o_mem_addr, o_ce_syndrome} = {f, a, s};
            @(negedge i_clk);
            {o_flags, o_mem_addr, o_ce_syndrome} = {4'h0, ~a, ~s};
        end
    endtask
endmodule

// File: testbench/ecmb_regs_tb_top.sv
`timescale 1ns/1ps
module ecmb_regs_tb_top;
    // Arbitrary version value
    localparam [2:0] VER = 3'h5;
    localparam [27:0] PG = 28'h01E0040;
    reg clk = 0, rst_n = 0, sel = 0, wr = 0, rd = 0, got;
    reg [1:0] sz = 0;
    reg [27:0] ad = 0;
    reg [31:0] wd = 0, rv;
    integer n_fail = 0, compares = 0, i;
    wire ack, bsel, gen, m0, m1, scr, cerp, uer, cst;
    wire [15:0] dd;
    wire [3:0] fl, dwr;
    wire [27:0] ma;
    wire [7:0] sy;
    wire [31:0] rdat;
    always #5 clk = ~clk;
    ecmb_mem_master bus (.i_clk(clk), .o_flags(fl), .o_mem_addr(ma), .o_ce_syndrome(sy));
    ecmb_regs #(.BOARD_SIZE(2'h1), .BOARD_VERSION(VER)) dut (.I_CORE_CLK(clk),
        .I_RESET_N(rst_n), .I_BOARD_NUM(2'h1), .I_REG_SEL(sel), .I_REG_WR(wr), .I_REG_RD(rd),
        .I_REG_ADDR(ad), .I_REG_SIZE(sz), .I_REG_WDATA(wd), .I_MEM_CYCLE(fl[3]),
        .I_MEM_ADDR(ma), .I_CE_DET(fl[2]), .I_UE_DET(fl[1]), .I_SCRUB_CYCLE(fl[0]),
        .I_CE_SYNDROME(sy), .O_REG_ACK(ack), .O_REG_RDATA(rdat), .O_BOARD_SEL(bsel),
        .O_CHECK_GEN_EN(gen), .O_SCRUB_EN(scr), .O_CHIP_MODE_SEL0(m0), .O_CHIP_MODE_SEL1(m1),
        .O_CE_REPORT(cerp), .O_UE_REPORT(uer), .O_CE_STATUS(cst), .O_DIAG_WR(dwr),
        .O_DIAG_DATA(dd));
    task chk(input [31:0] seen, input [31:0] exp, input [63:0] nm);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("MISMATCH %0s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task acc(input w, input [27:0] a, input [1:0] s, input [31:0] d);
        begin
            @(negedge clk);
            {sel, wr, rd, ad, sz, wd} = {1'b1, w, !w, a, s, d};
            @(negedge clk);
            {sel, wr, rd} = 3'h0;
            got = ack;
            rv = rdat;
        end
    endtask
    task finish_test;
        begin
            $display("compares %0d n_fail %0d", compares, n_fail);
            if (n_fail == 0 && compares > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask
    initial begin
        #200000;
        n_fail = n_fail + 1;
        finish_test;
    end
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1;
        repeat (4) @(negedge clk);
        acc(0, PG, 2'h2, 0);
        chk(rv, {16'h0, VER, 13'h0200}, "en_rst");
        bus.cyc(28'h1000000, 4'h8, 0);
        chk(bsel, 0, "sel_off");
        acc(0, PG ^ 28'h80, 2'h2, 0);
        chk(got, 0, "board");
        acc(0, PG + 28'h2000, 2'h2, 0);
        chk(got, 0, "page");
        acc(1, PG, 2'h1, 32'h08C4);
        @(negedge clk);
        chk({gen, m0, m1, scr}, 4'hC, "modes");
        acc(0, PG, 2'h2, 0);
        chk(rv, {16'h0, VER, 13'h0AC4}, "en_rd");
        for (i = 3; i < 7; i = i + 1) begin
            bus.cyc({i[5:0], 22'h0}, 4'h8, 0);
            chk(bsel, i == 4 || i == 5, "range");
        end
        bus.cyc(28'h1234568, 4'hC, 8'hA5);
        chk(cerp, 1, "ce_rep");
        bus.cyc(28'h1000010, 4'hC, 8'h3C);
        chk(cst, 1, "ce_set");
        acc(0, PG + 4, 2'h2, 0);
        chk(rv, {8'hA5, 23'h2468AD, 1'b1}, "ce_reg");
        acc(1, PG + 4, 2'h0, 0);
        chk(cst, 0, "ce_clr");
        bus.cyc(28'h1000000, 4'h3, 0);
        chk(uer, 0, "ue_scrub");
        bus.cyc(28'h1000000, 4'hA, 0);
        chk(uer, 1, "ue_bus");
        bus.cyc(28'h1000000, 4'h5, 8'h11);
        chk({cerp, cst}, 0, "ce_scrub");
        acc(1, PG + 8, 2'h0, 32'h1234);
        chk(dwr, 0, "diag_b");
        acc(1, PG + 8, 2'h1, 32'h1234);
        chk({dwr, dd}, {4'h1, 16'h1234}, "diag_w");
        acc(1, PG + 12, 2'h2, 32'h5678);
        chk({dwr, dd}, {4'hC, 16'h5678}, "diag_l");
        acc(0, PG + 8, 2'h2, 0);
        chk(rv, 0, "diag_rd");
        finish_test;
    end
endmodule
